// file: rlw_remote_latched_write_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "rlw_defs.svh"

module rlw_remote_latched_write_port (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Remote processor side.
	input wire logic remote_access_enable,
	input wire logic remote_write_strobe_b,
	input wire logic remote_read_strobe_b,
	input wire logic register_select,
	input wire logic [7:0] remote_data,
	input wire logic wait_b,
	output logic transfer_ack,
	output logic write_pending_flag_b,
	output logic read_path_start,
	// Shared memory buses.
	output logic local_bus_owner,
	output logic bus_oe_b,
	output logic data_write_b,
	output logic instruction_write_strobe_b,
	output logic [15:0] instruction_word,
	output logic [15:0] program_counter,
	// Local CPU timing unit.
	input wire logic bus_lock,
	input wire logic local_bus_request,
	output logic local_bus_grant,
	output logic remote_wait_stall,
	output rlw_pkg::rlw_state_t sm_state
);

	import rlw_pkg::*;

	rlw_state_t state_ff;
	rlw_state_t nxt_state;
	logic [7:0] dcr_ff;
	logic [2:0] ric_ff;
	logic [2:0] nxt_ric;
	logic mode_eff_ff;
	logic cmd_ff;
	logic [1:0] target_ff;
	logic upper_ff;
	logic nxt_upper;
	logic [7:0] hold_ff;
	logic [15:0] iword_ff;
	logic [15:0] pc_ff;
	logic [15:0] nxt_pc;
	logic owner_ff;
	logic oe_b_ff;
	logic dwr_b_ff;
	logic iwr_b_ff;
	logic rdstart_ff;
	logic ahb_wr_ff;
	logic [11:0] ahb_addr_ff;
	logic [31:0] hrdata_ff;
	logic dw_zero;
	logic iw_zero;

	// Remote cycle decode, sampled once per T-state.
	wire remote_write_strobe = remote_access_enable & ~remote_write_strobe_b;
	wire remote_read_strobe = remote_access_enable & ~remote_read_strobe_b;
	wire rem_any = remote_write_strobe | remote_read_strobe;

	// State groups.
	wire st_idle = (state_ff == RLW_IDLE);
	wire st_hand = (state_ff == RLW_HAND);
	wire st_setup = (state_ff == RLW_SETUP);
	wire st_data_memory = (state_ff == RLW_DATA_MEMORY);
	wire st_ihi = (state_ff == RLW_IHI);
	wire st_access = (state_ff == RLW_RIC) | (state_ff == RLW_PCL) | (state_ff == RLW_PCH) |
		st_data_memory | (state_ff == RLW_ILO) | st_ihi;
	wire st_pending = ~st_idle & (state_ff != RLW_LATCH);
	// Owned span: from takeover to the end of the access, local requests are refused.
	wire st_owned = (state_ff == RLW_TAKE) | st_setup | st_access | (state_ff == RLW_DONE);
	wire free_bus = st_idle | (state_ff == RLW_LATCH) | (state_ff == RLW_PEND) | st_hand;

	// Local grant only while nobody else is using the buses.
	assign local_bus_grant = bus_lock & local_bus_request & free_bus; // [RULE_02] [RULE_15]
	// A CPU that does not ask for the bus is never stalled by the remote write.
	assign remote_wait_stall = local_bus_request & st_owned; // [RULE_07] [RULE_18] [RULE_21]

	// Acknowledge is pulled low only for accesses arriving while a write is pending.
	// Deriving it and the pending flag from one state register makes them rise together.
	assign transfer_ack = ~(rem_any & st_pending); // [RULE_01] [RULE_06] [RULE_15] [RULE_20]
	assign write_pending_flag_b = ~st_pending; // [RULE_05]

	// Wait-state completion for the current access kind.
	wire waits_done = st_data_memory ? dw_zero : (st_ihi ? iw_zero : 1'b1);
	wire mode_on = mode_eff_ff;

	// Next state of the remote access state machine.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RLW_IDLE: begin
				if (mode_on && remote_write_strobe) begin
					nxt_state = RLW_LATCH; // [RULE_03]
				end
			end
			RLW_LATCH: begin
				if (!remote_write_strobe) begin
					nxt_state = RLW_PEND; // [RULE_03] [RULE_04]
				end
			end
			RLW_PEND: begin
				if (!local_bus_grant) begin
					nxt_state = RLW_TAKE; // [RULE_07]
				end
			end
			RLW_TAKE: begin
				nxt_state = RLW_SETUP; // [RULE_18]
			end
			RLW_SETUP: begin
				if (cmd_ff) begin
					nxt_state = RLW_RIC; // [RULE_09]
				end else begin
					case (target_ff)
						`RLW_MS_PCL: nxt_state = RLW_PCL; // [RULE_10]
						`RLW_MS_PCH: nxt_state = RLW_PCH; // [RULE_10]
						`RLW_MS_DATA_MEMORY: nxt_state = RLW_DATA_MEMORY; // [RULE_11]
						default: nxt_state = upper_ff ? RLW_IHI : RLW_ILO; // [RULE_12]
					endcase
				end
			end
			RLW_RIC, RLW_PCL, RLW_PCH, RLW_DATA_MEMORY, RLW_ILO, RLW_IHI: begin
				if (waits_done && wait_b) begin
					nxt_state = RLW_DONE; // [RULE_14]
				end
			end
			RLW_DONE: begin
				nxt_state = RLW_HAND;
			end
			RLW_HAND: begin
				if (remote_write_strobe && mode_on) begin
					nxt_state = RLW_LATCH; // [RULE_17]
				end else begin
					nxt_state = RLW_IDLE; // [RULE_17]
				end
			end
			default: begin
				nxt_state = RLW_IDLE;
			end
		endcase
	end

	// Output strobes registered from the next state so they change cleanly at the edge.
	wire nxt_owner = (nxt_state == RLW_SETUP) | (nxt_state == RLW_RIC) | (nxt_state == RLW_PCL) |
		(nxt_state == RLW_PCH) | (nxt_state == RLW_DATA_MEMORY) | (nxt_state == RLW_ILO) |
		(nxt_state == RLW_IHI) | (nxt_state == RLW_DONE); // [RULE_08] [RULE_14] [RULE_15]
	// Buses float from takeover through handback; the half T-state is rounded to a whole one.
	wire nxt_float = nxt_owner | (nxt_state == RLW_TAKE) | (nxt_state == RLW_HAND); // [RULE_08] [RULE_15]
	wire nxt_dwr_b = ~(nxt_state == RLW_DATA_MEMORY); // [RULE_11] [RULE_19]
	wire nxt_iwr_b = ~(nxt_state == RLW_IHI); // [RULE_12]
	wire nxt_rdstart = st_hand & ~(remote_write_strobe & mode_on) & remote_read_strobe; // [RULE_17]

	// Wait-state counters loaded as the setup T-state begins.
	wire [2:0] dcr_dw = dcr_ff[`RLW_DCR_DW_MSB:`RLW_DCR_DW_LSB];
	wire [1:0] dcr_iw = dcr_ff[`RLW_DCR_IW_MSB:`RLW_DCR_IW_LSB];
	wire cnt_load = (state_ff == RLW_TAKE); // [RULE_08]

	rlw_wait_counter #(.W(3)) u_data_wait (
		.clock(clock),
		.rst_b(rst_b),
		.load(cnt_load),
		.load_value(dcr_dw),
		.count_en(st_data_memory),
		.zero(dw_zero)
	);

	rlw_wait_counter #(.W(2)) u_instr_wait (
		.clock(clock),
		.rst_b(rst_b),
		.load(cnt_load),
		.load_value(dcr_iw),
		.count_en(st_ihi),
		.zero(iw_zero)
	);

	// AHB-Lite decode; every transfer finishes with no wait state and an OKAY answer.
	wire ahb_take = hsel & hready & htrans[1];
	wire [11:0] ahb_ofs = {haddr[11:2], 2'b00};
	wire wr_dcr = ahb_wr_ff & (ahb_addr_ff == `RLW_OFS_DCR);
	wire wr_ric = ahb_wr_ff & (ahb_addr_ff == `RLW_OFS_RIC);
	wire wr_pc = ahb_wr_ff & (ahb_addr_ff == `RLW_OFS_PC);
	wire [31:0] status_word = {27'h0000000, remote_wait_stall, mode_eff_ff, upper_ff, owner_ff, st_pending};
	wire [31:0] rd_mux = (ahb_ofs == `RLW_OFS_DCR) ? {24'h000000, dcr_ff} :
		(ahb_ofs == `RLW_OFS_RIC) ? {29'h00000000, ric_ff} :
		(ahb_ofs == `RLW_OFS_PC) ? {16'h0000, pc_ff} :
		(ahb_ofs == `RLW_OFS_STATUS) ? status_word :
		(ahb_ofs == `RLW_OFS_IWORD) ? {16'h0000, iword_ff} : 32'h00000000;

	// Configuration writes; a remote write to the interface register wins over the bus.
	wire rem_ric = (state_ff == RLW_RIC);
	assign nxt_ric = rem_ric ? remote_data[2:0] : (wr_ric ? hwdata[2:0] : ric_ff); // [RULE_09]
	wire ms_to_instruction_memory = (rem_ric && remote_data[1:0] == `RLW_MS_INSTRUCTION_MEMORY) ||
		(wr_ric && hwdata[1:0] == `RLW_MS_INSTRUCTION_MEMORY);

	// Upper-byte flag: the completion toggle wins over a same-cycle realign.
	wire instruction_memory_done = st_hand & ~cmd_ff & (target_ff == `RLW_MS_INSTRUCTION_MEMORY);
	assign nxt_upper = instruction_memory_done ? ~upper_ff : (ms_to_instruction_memory ? 1'b0 : upper_ff); // [RULE_13] [RULE_16]

	// Program counter: remote loads and increments take priority over the bus.
	always_comb begin
		nxt_pc = pc_ff;
		if (state_ff == RLW_PCL) begin
			nxt_pc = {pc_ff[15:8], remote_data}; // [RULE_10]
		end else if (state_ff == RLW_PCH) begin
			nxt_pc = {remote_data, pc_ff[7:0]}; // [RULE_10]
		end else if (instruction_memory_done && upper_ff) begin
			nxt_pc = pc_ff + 16'h0001; // [RULE_16]
		end else if (wr_pc) begin
			nxt_pc = hwdata[15:0];
		end
	end

	// Select is sampled at the start of an access and again when pending rises.
	wire cmd_sample = (st_idle & (nxt_state == RLW_LATCH)) | st_hand; // [RULE_22]

	// State and strobe registers.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= RLW_IDLE; // [RULE_23]
			owner_ff <= 1'b0; // [RULE_23]
			oe_b_ff <= 1'b0;
			dwr_b_ff <= 1'b1;
			iwr_b_ff <= 1'b1;
			rdstart_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			owner_ff <= nxt_owner;
			oe_b_ff <= nxt_float;
			dwr_b_ff <= nxt_dwr_b;
			iwr_b_ff <= nxt_iwr_b;
			rdstart_ff <= nxt_rdstart;
		end
	end

	// Access context: select sample, target and upper-byte flag.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cmd_ff <= 1'b0;
			target_ff <= `RLW_MS_DATA_MEMORY;
			upper_ff <= 1'b0; // [RULE_13]
		end else begin
			if (cmd_sample) begin
				cmd_ff <= register_select; // [RULE_22]
			end
			if (st_pending && state_ff == RLW_TAKE) begin
				target_ff <= ric_ff[`RLW_RIC_MS_MSB:`RLW_RIC_MS_LSB];
			end
			upper_ff <= nxt_upper;
		end
	end

	// Instruction word assembly: low byte held, high byte completes the word.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hold_ff <= 8'h00;
			iword_ff <= 16'h0000;
		end else begin
			if (state_ff == RLW_ILO) begin
				hold_ff <= remote_data; // [RULE_12]
			end
			if (st_ihi) begin
				iword_ff <= {remote_data, hold_ff}; // [RULE_12]
			end
		end
	end

	// Configuration registers; the latched-write mode bit only takes effect
	// one T-state after the write that changed it has handed the bus back,
	// so the access in flight never sees its own mode change.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dcr_ff <= `RLW_DCR_RESET;
			ric_ff <= `RLW_RIC_RESET;
			mode_eff_ff <= `RLW_MODE_RESET;
			pc_ff <= `RLW_PC_RESET;
		end else begin
			if (wr_dcr) begin
				dcr_ff <= hwdata[7:0];
			end
			ric_ff <= nxt_ric;
			if (st_idle || st_hand) begin
				mode_eff_ff <= ric_ff[`RLW_RIC_LW_BIT]; // [RULE_09]
			end
			pc_ff <= nxt_pc;
		end
	end

	// Bus slave: address phase captured, read data registered for the data phase.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ahb_wr_ff <= 1'b0;
			ahb_addr_ff <= 12'h000;
			hrdata_ff <= 32'h00000000;
		end else begin
			ahb_wr_ff <= ahb_take & hwrite;
			if (ahb_take) begin
				ahb_addr_ff <= ahb_ofs;
			end
			if (ahb_take && !hwrite) begin
				hrdata_ff <= rd_mux;
			end
		end
	end

	// Port drive.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign local_bus_owner = owner_ff;
	assign bus_oe_b = oe_b_ff;
	assign data_write_b = dwr_b_ff;
	assign instruction_write_strobe_b = iwr_b_ff;
	assign instruction_word = iword_ff;
	assign program_counter = pc_ff;
	assign read_path_start = rdstart_ff;
	assign sm_state = state_ff;

	// Transfer size is not checked: only whole-word accesses are supported.
	wire unused_ok = &{1'b0, hsize, haddr[31:12], haddr[1:0], hwdata[31:16]};

endmodule

`default_nettype wire

// file: rlw_defs.svh
// Overview of operation
// [RULE_01] Latched-write mode accepts a remote write without pulling the acknowledge low.
// [RULE_02] While idle, grant local bus requests whenever buses are free and lock is high.
// [RULE_03] Enter latch-wait one clock after enable plus write strobe; stay until strobe ends.
// [RULE_04] External logic latches address and data on the trailing write strobe edge.
// [RULE_05] After the remote write ends, hold write pending low until the write completes.
// [RULE_06] Any remote access started while write pending is low pulls the acknowledge low.
// [RULE_07] Local access in progress finishes first; then no grants and CPU data access stalls.
// [RULE_08] Next clock: bus owner high, buses floated, wait counters loaded from configuration.
// [RULE_09] Register select high writes the interface configuration; mode change lags one T-state.
// [RULE_10] Target select 10 loads the low program counter byte, 11 the high byte.
// [RULE_11] Target 00 writes data memory with strobe low, repeated over programmed data waits.
// [RULE_12] Target 01: low byte into holding latch; high byte writes the word with waits.
// [RULE_13] Upper-byte flag clears on reset and whenever 01 is written to target select; the code lets a same-cycle completion toggle win over it.
// [RULE_14] Loop on the access while wait input low; next state drops strobe, keeps owner/pending.
// [RULE_15] Final state: owner low, buses floated, local grant allowed, acknowledge low on new access.
// [RULE_16] Instruction write completion toggles the upper-byte flag; high byte increments the PC.
// [RULE_17] After final state: pending write to latch-wait, pending read to read path, else idle.
// [RULE_18] Bus takeover waits one T-state before switching, stalling the timing unit meanwhile.
// [RULE_19] Address settles one T-state, strobe low for one plus data waits, owner drops after.
// [RULE_20] Second write is stalled; acknowledge and write pending rise together after owner falls.
// [RULE_21] With the CPU not needing the bus, the remote write runs without stalling it.
// [RULE_22] Register select is sampled for the next access when write pending rises.
// [RULE_23] Reset returns to idle with pending and acknowledge high and bus owner low.
`ifndef RLW_DEFS_SVH
`define RLW_DEFS_SVH

// Register byte offsets on the bus.
`define RLW_OFS_DCR 12'h000
`define RLW_OFS_RIC 12'h004
`define RLW_OFS_PC 12'h008
`define RLW_OFS_STATUS 12'h00C
`define RLW_OFS_IWORD 12'h010

// Device configuration fields.
`define RLW_DCR_DW_LSB 0
`define RLW_DCR_DW_MSB 2
`define RLW_DCR_IW_LSB 4
`define RLW_DCR_IW_MSB 5
`define RLW_DCR_RESET 8'h00

// Remote interface configuration fields.
`define RLW_RIC_MS_LSB 0
`define RLW_RIC_MS_MSB 1
`define RLW_RIC_LW_BIT 2
`define RLW_RIC_RESET 3'h4
`define RLW_MODE_RESET 1'b1

// Memory target select codes.
`define RLW_MS_DATA_MEMORY 2'h0
`define RLW_MS_INSTRUCTION_MEMORY 2'h1
`define RLW_MS_PCL 2'h2
`define RLW_MS_PCH 2'h3

// Status bit positions.
`define RLW_ST_PEND 0
`define RLW_ST_OWNER 1
`define RLW_ST_UPPER 2
`define RLW_ST_MODE 3
`define RLW_ST_STALL 4

`define RLW_PC_RESET 16'h0000

`endif

// file: rlw_pkg.sv
package rlw_pkg;

	// Remote access state machine, latched-write path.
	typedef enum logic [3:0] {
		RLW_IDLE,
		RLW_LATCH,
		RLW_PEND,
		RLW_TAKE,
		RLW_SETUP,
		RLW_RIC,
		RLW_PCL,
		RLW_PCH,
		RLW_DATA_MEMORY,
		RLW_ILO,
		RLW_IHI,
		RLW_DONE,
		RLW_HAND
	} rlw_state_t;

endpackage

// file: rlw_wait_counter.sv
`timescale 1ns/1ns
`default_nettype none

// Programmed wait-state counter: loads a count, counts down to zero.
module rlw_wait_counter #(
	parameter int W = 3
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Control.
	input wire logic load,
	input wire logic [W-1:0] load_value,
	input wire logic count_en,
	// Status.
	output logic zero
);

	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	// Load wins over counting; counting stops at zero.
	assign nxt_count = load ? load_value :
		(count_en && count_ff != '0) ? count_ff - {{(W-1){1'b0}}, 1'b1} : count_ff;
	assign zero = (count_ff == '0);

	// Count register.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

endmodule

`default_nettype wire

// file: rlw_asserts.sv
`timescale 1ns/1ns
`default_nettype none

// Watches the latched-write port from its pins only.
module rlw_asserts import rlw_pkg::*; (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Remote side.
	input wire logic remote_access_enable,
	input wire logic remote_write_strobe_b,
	input wire logic remote_read_strobe_b,
	input wire logic wait_b,
	input wire logic transfer_ack,
	input wire logic write_pending_flag_b,
	// Buses and local CPU.
	input wire logic local_bus_owner,
	input wire logic bus_oe_b,
	input wire logic data_write_b,
	input wire logic bus_lock,
	input wire logic local_bus_request,
	input wire logic local_bus_grant,
	input wire logic remote_wait_stall,
	input wire rlw_pkg::rlw_state_t sm_state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Remote requests as seen on the pins.
	wire logic wr_req = remote_access_enable && !remote_write_strobe_b;
	wire logic any_req = remote_access_enable && !(remote_write_strobe_b && remote_read_strobe_b);
	// Takeover, setup and release steps of one access.
	sequence s_take; sm_state == RLW_TAKE; endsequence
	sequence s_setup; sm_state == RLW_SETUP && local_bus_owner && bus_oe_b; endsequence
	sequence s_release; sm_state == RLW_DONE && local_bus_owner ##1 !local_bus_owner && !write_pending_flag_b; endsequence
	a_no_ack_write: assert property (sm_state inside {RLW_IDLE, RLW_LATCH} |-> transfer_ack)
		else $error("acknowledge low in idle or latch");
	a_idle_grant: assert property (sm_state == RLW_IDLE && bus_lock && local_bus_request |-> local_bus_grant)
		else $error("idle request not granted");
	a_latch_entry: assert property (sm_state == RLW_IDLE && wr_req |=> sm_state == RLW_LATCH)
		else $error("write strobe did not enter latch wait");
	a_pend_after: assert property (sm_state == RLW_LATCH && !wr_req |=> !write_pending_flag_b)
		else $error("pending flag not asserted after write");
	a_pend_ack: assert property (!write_pending_flag_b && any_req |-> !transfer_ack)
		else $error("access while pending not stalled");
	a_owned_grant: assert property (sm_state inside {[RLW_TAKE:RLW_DONE]} |-> !local_bus_grant)
		else $error("grant given while remote owns buses");
	a_take_setup: assert property (s_take |=> s_setup)
		else $error("setup without owner or floated buses");
	a_data_memory_strobe: assert property (sm_state == RLW_DATA_MEMORY |-> !data_write_b && bus_oe_b)
		else $error("data write strobe not low in access");
	a_wait_loop: assert property (sm_state == RLW_DATA_MEMORY && !wait_b |=> sm_state == RLW_DATA_MEMORY)
		else $error("access left while wait low");
	a_strobe_end: assert property ($rose(data_write_b) |-> s_release)
		else $error("owner release order wrong");
	a_hand_relatch: assert property (sm_state == RLW_HAND && wr_req |=> sm_state == RLW_LATCH && transfer_ack && write_pending_flag_b)
		else $error("second write not resumed");
	a_stall_req: assert property (sm_state inside {[RLW_SETUP:RLW_DONE]} |-> remote_wait_stall == local_bus_request)
		else $error("stall does not follow request");
endmodule

bind rlw_remote_latched_write_port rlw_asserts chk (.*);

`default_nettype wire

// file: rlw_remote_host.sv
`timescale 1ns/1ns
`default_nettype none

// Remote processor with its external data latch.
module rlw_remote_host (
	// Clock and reply.
	input wire logic clock,
	input wire logic transfer_ack,
	// Strobes and latched values.
	output logic remote_access_enable = 1'b0,
	output logic remote_write_strobe_b = 1'b1,
	output logic remote_read_strobe_b = 1'b1,
	output logic register_select = 1'b0,
	output logic [7:0] remote_data = 8'h00
);
	logic [7:0] bus_data = 8'h00;

	// The latch closes on the trailing strobe edge, so the port sees settled data.
	always @(posedge remote_write_strobe_b) remote_data <= bus_data;

	// One remote cycle; a low acknowledge holds the strobe until it rises.
	task access(input logic wr, input logic cmd, input logic [7:0] d, output logic stalled);
		@(posedge clock);
		remote_access_enable <= 1'b1;
		register_select <= cmd;
		bus_data <= d;
		remote_write_strobe_b <= !wr;
		remote_read_strobe_b <= wr;
		@(posedge clock);
		stalled = !transfer_ack;
		while (transfer_ack !== 1'b1) @(posedge clock);
		remote_access_enable <= 1'b0;
		remote_write_strobe_b <= 1'b1;
		remote_read_strobe_b <= 1'b1;
	endtask
endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "rlw_defs.svh"

module tb;
	import rlw_pkg::*;
	logic clock = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic remote_access_enable, remote_write_strobe_b, remote_read_strobe_b, register_select;
	logic [7:0] remote_data, wlow = 8'h00, pulses = 8'h00, iwlow = 8'h00, base;
	logic wait_b = 1'b1, bus_lock = 1'b0, local_bus_request = 1'b0, st, s2;
	logic transfer_ack, write_pending_flag_b, read_path_start, local_bus_owner, bus_oe_b;
	logic data_write_b, instruction_write_strobe_b, local_bus_grant, remote_wait_stall;
	logic [15:0] instruction_word, program_counter;
	rlw_state_t sm_state;
	int compares = 0, miscompares = 0, cyc = 0;

	assign hready = hreadyout;
	always #10 clock = ~clock;
	rlw_remote_latched_write_port uut (.*);
	rlw_remote_host host (.*);

	// Strobe and hand-off counters; the watchdog ends a hung run.
	always @(posedge clock) begin
		if (!data_write_b) wlow <= wlow + 8'h01;
		if (read_path_start) pulses <= pulses + 8'h01;
		if (!instruction_write_strobe_b) iwlow <= iwlow + 8'h01;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			end_of_test();
		end
	end

	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask

	// Single word transfer; read data is taken at the edge ending the data phase.
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h00000, a};
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task idle_wait;
		do @(posedge clock); while (sm_state !== RLW_IDLE);
	endtask

	task rw(input logic [8:0] v);
		host.access(1'b1, v[8], v[7:0], st);
		chk("stall", st, 1'b0);
		idle_wait();
	endtask

	task t_reset;
		chk("state", sm_state, RLW_IDLE);
		chk("flags", {transfer_ack, write_pending_flag_b, local_bus_owner}, 3'h6);
		ahb(1'b0, `RLW_OFS_RIC, 32'h0);
		chk("ric", r, 32'h4);
	endtask

	// Two data waits give a strobe of three cycles; a low wait input holds the access.
	task t_data_memory;
		ahb(1'b1, `RLW_OFS_DCR, 32'h2);
		ahb(1'b0, `RLW_OFS_DCR, 32'h0);
		chk("dcr", r, 32'h2);
		base = wlow;
		rw(9'h05A);
		chk("wr_low", wlow - base, 8'h3);
		wait_b <= 1'b0;
		host.access(1'b1, 1'b0, 8'hA5, st);
		repeat (8) @(posedge clock);
		chk("held", sm_state, RLW_DATA_MEMORY);
		chk("no_stall", remote_wait_stall, 1'b0);
		ahb(1'b0, `RLW_OFS_STATUS, 32'h0);
		chk("status", r, 32'hB);
		wait_b <= 1'b1;
		idle_wait();
	endtask

	// Accesses issued while a write is pending are stalled, then served in turn.
	task t_b2b;
		host.access(1'b1, 1'b0, 8'h11, st);
		host.access(1'b1, 1'b1, 8'h06, s2);
		chk("second", s2, 1'b1);
		base = pulses;
		host.access(1'b0, 1'b0, 8'h00, st);
		chk("read", st, 1'b1);
		idle_wait();
		@(posedge clock);
		chk("handoff", pulses - base, 8'h1);
		ahb(1'b0, `RLW_OFS_RIC, 32'h0);
		chk("ric_b2b", r, 32'h6);
	endtask

	// Counter bytes, two instruction words, and a realign between low bytes.
	task t_pc;
		logic [8:0] seq [11] = '{9'h106, 9'h034, 9'h107, 9'h012, 9'h105, 9'h0CD, 9'h0AB,
			9'h0EE, 9'h105, 9'h077, 9'h066};
		ahb(1'b1, `RLW_OFS_DCR, 32'h12);
		base = iwlow;
		foreach (seq[i]) rw(seq[i]);
		chk("iwr_low", iwlow - base, 8'h4);
		chk("pc_pin", program_counter, 16'h1236);
		chk("word", instruction_word, 16'h6677);
		ahb(1'b0, `RLW_OFS_PC, 32'h0);
		chk("pc", r, 32'h1236);
		ahb(1'b0, `RLW_OFS_RIC, 32'h0);
		chk("ric", r, 32'h5);
		ahb(1'b0, `RLW_OFS_IWORD, 32'h0);
		chk("iword", r, 32'h6677);
	endtask

	// A local access holds the pending write; once taken over, requests are stalled.
	task t_grant;
		bus_lock <= 1'b1;
		local_bus_request <= 1'b1;
		@(negedge clock);
		chk("grant", local_bus_grant, 1'b1);
		host.access(1'b1, 1'b0, 8'h3C, st);
		repeat (5) @(posedge clock);
		chk("waits", sm_state, RLW_PEND);
		local_bus_request <= 1'b0;
		@(posedge clock);
		local_bus_request <= 1'b1;
		@(negedge clock);
		chk("blocked", local_bus_grant, 1'b0);
		@(negedge clock);
		chk("stalled", remote_wait_stall, 1'b1);
		while (sm_state !== RLW_HAND) @(negedge clock);
		chk("hand", local_bus_grant, 1'b1);
		@(posedge clock);
		local_bus_request <= 1'b0;
		idle_wait();
	endtask

	// A reset in mid-run clears the upper-byte flag left set by a lone low byte.
	task t_rst2;
		ahb(1'b0, `RLW_OFS_STATUS, 32'h0);
		chk("status_pre", r, 32'hC);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		ahb(1'b0, `RLW_OFS_STATUS, 32'h0);
		chk("status_rst", r, 32'h8);
		chk("pc_rst", program_counter, 16'h0000);
	endtask

	task end_of_test;
		if (miscompares == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_data_memory();
		t_b2b();
		t_pc();
		t_grant();
		t_rst2();
		end_of_test();
	end
endmodule

`default_nettype wire
